// *** logic/_unused_placeholder_never.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** logic/magnetic_field_signal_path.sv ***
/*
  Customer temperature compensation, low-pass filter and result registers.
  Assumes factory-compensated samples and temperature readings arrive
  synchronous to clk, and a SENT framer pulses message_start.
*/
`timescale 1ns/1ps
`default_nettype none
module magnetic_field_signal_path #(
  parameter int TICK_CYCLES = signal_path_pkg::TICK_CYCLES,
  parameter int TEMP_REFRESH_CYCLES = signal_path_pkg::TEMP_REFRESH_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] factory_comp_field,
  input wire logic factory_comp_valid,
  output logic factory_comp_ready,
  input wire logic [19:0] temperature_raw,
  input wire logic temperature_raw_valid,
  output logic temperature_request,
  input wire signal_path_pkg::coef_type config_area,
  input wire logic config_load,
  input wire logic programming_mode,
  input wire logic message_start,
  output logic [15:0] field_result_reg,
  output logic [15:0] temperature_result_reg,
  output logic [15:0] sent_field_word,
  output logic sent_field_valid,
  output logic [2:0] range_select
);
  typedef struct packed {
    signal_path_pkg::coef_type coef;
    logic signed [15:0] temperature_reading;
    logic [15:0] field_res;
    logic [15:0] temp_res;
    logic [15:0] sent_word;
    logic sent_valid;
    logic temp_req;
    logic [12:0] tick_cnt;
    logic [6:0] samp_cnt;
    logic samp_en;
    logic [22:0] temp_cnt;
    logic comp_valid;
    logic signed [15:0] comp;
    logic signed [17:0] filt1;
    logic signed [17:0] filt2;
  } path_state_type;

  path_state_type st_reg, st_next;
  logic [15:0] fifo_data;
  logic fifo_valid;
  logic fifo_in_ready;
  logic take;

  // Samples queue until the sample clock consumes them
  sample_fifo #(.WIDTH(16), .DEPTH(signal_path_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_data(factory_comp_field),
    .in_valid(factory_comp_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(st_reg.samp_en)
  );
  assign take = st_reg.samp_en && fifo_valid;

  // Saturate a wide signed value to 16 bits
  function automatic logic [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sd32767) begin
      return signal_path_pkg::RESULT_MAX;
    end else if (v < -40'sd32768) begin
      return signal_path_pkg::RESULT_MIN;
    end
    return v[15:0];
  endfunction

  // Sample period in 0.5 ms ticks per selection code
  function automatic logic [6:0] period_ticks(input logic [4:0] fs);
    unique case (fs)
      signal_path_pkg::FS_1000HZ: return 7'h02;
      signal_path_pkg::FS_500HZ: return 7'h04;
      signal_path_pkg::FS_250HZ: return 7'h08;
      signal_path_pkg::FS_125HZ: return 7'h10;
      signal_path_pkg::FS_62HZ: return 7'h20;
      signal_path_pkg::FS_31HZ: return 7'h40;
      default: return 7'h01;      // Unlisted codes run at 2 kHz
    endcase
  endfunction

  // Arithmetic, wide enough that only the final step can overflow
  logic signed [39:0] t_sq, sens_q, off_q, sum_q, prod_q, temp_wide;
  logic signed [39:0] filt_in, f1_new, f2_new, filt_out;
  logic [15:0] masked;
  logic first_order;

  // Polynomials and product
  always_comb begin
    t_sq = 40'(st_reg.temperature_reading) * 40'(st_reg.temperature_reading);
    // Sensitivity c0 + c1*T + c2*T^2
    sens_q = (40'(st_reg.coef.sens_const_coef) <<< signal_path_pkg::SENS_CONST_SHL)
      + ((40'(st_reg.coef.sens_linear_coef) * 40'(st_reg.temperature_reading))
         >>> signal_path_pkg::SENS_LIN_SHR)
      + ((40'(st_reg.coef.sens_quadratic_coef) * t_sq) >>> signal_path_pkg::SENS_QUAD_SHR);
    // Offset d0 + d1*T
    off_q = (40'(st_reg.coef.offset_const_coef) <<< signal_path_pkg::OFF_CONST_SHL)
      + ((40'(st_reg.coef.offset_linear_coef) * 40'(st_reg.temperature_reading))
         >>> signal_path_pkg::OFF_LIN_SHR);
    // Factory value first, then customer terms; sum in Q15, sensitivity in Q12
    sum_q = 40'($signed(fifo_data)) + off_q;
    prod_q = (sum_q * sens_q) >>> signal_path_pkg::SENS_FRAC;
    temp_wide = 40'($signed(temperature_raw));
  end

  // Filter stages; first order at 1 and 2 kHz, two cascaded poles below
  always_comb begin
    first_order = (st_reg.coef.filter_sample_select == signal_path_pkg::FS_2000HZ)
      || (st_reg.coef.filter_sample_select == signal_path_pkg::FS_1000HZ);
    filt_in = 40'(st_reg.comp);
    f1_new = 40'(st_reg.filt1) + ((filt_in - 40'(st_reg.filt1)) >>> 1);
    f2_new = 40'(st_reg.filt2) + ((f1_new - 40'(st_reg.filt2)) >>> 1);
    filt_out = first_order ? f1_new : f2_new;
    masked = sat16(filt_out);
    // Fast rates carry fewer meaningful bits
    if (st_reg.coef.filter_sample_select == signal_path_pkg::FS_2000HZ) begin
      masked[2:0] = 3'h0;
    end else if (st_reg.coef.filter_sample_select == signal_path_pkg::FS_1000HZ) begin
      masked[0] = 1'b0;
    end
  end

  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.sent_valid = 1'b0;
    st_next.temp_req = 1'b0;
    st_next.samp_en = 1'b0;
    // Configuration words from memory, held between loads
    if (config_load) begin
      st_next.coef = config_area;
    end
    // Base tick divider and sample enable
    if (st_reg.tick_cnt == 13'(TICK_CYCLES - 1)) begin
      st_next.tick_cnt = '0;
      if (st_reg.samp_cnt >= period_ticks(st_reg.coef.filter_sample_select) - 7'h01) begin
        st_next.samp_cnt = '0;
        st_next.samp_en = 1'b1;
      end else begin
        st_next.samp_cnt = st_reg.samp_cnt + 7'h01;
      end
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 13'h0001;
    end
    // Temperature refresh request
    if (st_reg.temp_cnt == 23'(TEMP_REFRESH_CYCLES - 1)) begin
      st_next.temp_cnt = '0;
      st_next.temp_req = 1'b1;
    end else begin
      st_next.temp_cnt = st_reg.temp_cnt + 23'h000001;
    end
    // New temperature replaces old; otherwise the last one stays
    if (temperature_raw_valid) begin
      st_next.temperature_reading = sat16(temp_wide);
      st_next.temp_res = sat16(temp_wide);
    end
    // Stage one: compensated sample
    st_next.comp_valid = take;
    if (take) begin
      st_next.comp = sat16(prod_q);
    end
    // Stage two: filter and result register
    if (st_reg.comp_valid) begin
      st_next.filt1 = 18'(f1_new);
      st_next.filt2 = 18'(f2_new);
      st_next.field_res = masked;
    end
    // Transmit copy only while streaming
    if (message_start && !programming_mode) begin
      st_next.sent_word = st_reg.field_res;
      st_next.sent_valid = 1'b1;
    end
    // Reset: results show negative overflow until real data
    if (!reset_n) begin
      st_next = '0;
      st_next.field_res = signal_path_pkg::RESULT_RESET;
      st_next.temp_res = signal_path_pkg::RESULT_RESET;
      st_next.sent_word = signal_path_pkg::RESULT_RESET;
    end
  end

  // State register; the FIFO ready is itself a flop
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign factory_comp_ready = fifo_in_ready;
  assign field_result_reg = st_reg.field_res;
  assign temperature_result_reg = st_reg.temp_res;
  assign sent_field_word = st_reg.sent_word;
  assign sent_field_valid = st_reg.sent_valid;
  assign temperature_request = st_reg.temp_req;
  assign range_select = st_reg.coef.range_select;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_RESET_VALUE: assert property ($rose(reset_n) |-> field_result_reg == 16'h8000 &&
    temperature_result_reg == 16'h8000) else $error("results not at negative overflow");
  AST_LATCH: assert property (message_start && !programming_mode |=>
    sent_field_valid && sent_field_word == $past(field_result_reg)) else $error("latch miss");
  AST_PROG_QUIET: assert property (programming_mode |=> !sent_field_valid)
    else $error("stream in programming mode");
  AST_TEMP_SAT: assert property (temperature_raw_valid && $signed(temperature_raw) > 20'sd32767
    |=> temperature_result_reg == 16'h7FFF) else $error("temperature not saturated");
  AST_TEMP_LOAD: assert property (temperature_raw_valid && $signed(temperature_raw) <= 20'sd32767
    && $signed(temperature_raw) >= -20'sd32768 |=> temperature_result_reg ==
    $past(temperature_raw[15:0])) else $error("temperature not stored");
  AST_TEMP_HOLD: assert property (!temperature_raw_valid |=>
    $stable(st_reg.temperature_reading)) else $error("temperature changed without update");
  AST_FIELD_HOLD: assert property (!st_reg.comp_valid |=> $stable(field_result_reg))
    else $error("field result changed without sample");
  AST_RES13: assert property (st_reg.comp_valid && config_area.filter_sample_select == 5'h00 &&
    st_reg.coef.filter_sample_select == 5'h00 |=> field_result_reg[2:0] == 3'h0)
    else $error("low bits set at 2 kHz");
  AST_SAMPLE_PIPE: assert property (take |=> st_reg.comp_valid ##1 !st_reg.comp_valid)
    else $error("sample pipeline broken");
  AST_TEMP_REQ: assert property (temperature_request |=> !temperature_request)
    else $error("refresh request not a pulse");

  COV_SENT: cover property (message_start && !programming_mode ##1 sent_field_valid);
  COV_SAMPLE: cover property (take ##2 $changed(field_result_reg));
  COV_FULL: cover property (!factory_comp_ready);
  COV_TEMP: cover property (temperature_raw_valid ##1 $changed(temperature_result_reg));
endmodule // magnetic_field_signal_path
`default_nettype wire

// *** logic/sample_fifo.sv ***
/*
  Sample FIFO with registered read data and valid/ready on both sides.
  Assumes the consumer may stall indefinitely; full stops the producer.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;      // Entries held in memory, excluding output stage
    logic full;
    logic valid;
    logic [WIDTH-1:0] data;
  } fifo_state_type;

  fifo_state_type st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];   // Storage array
  logic push, pop;

  // Handshakes from registered flags only
  assign push = in_valid && !st_reg.full;
  assign pop = (st_reg.count != '0) && (!st_reg.valid || out_ready);
  assign in_ready = !st_reg.full;
  assign out_data = st_reg.data;
  assign out_valid = st_reg.valid;

  // Next state
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      st_next.data = mem[st_reg.rd_ptr];
      st_next.valid = 1'b1;
    end else if (out_ready) begin
      st_next.valid = 1'b0;
    end
    st_next.count = st_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    st_next.full = (st_next.count == (AW+1)'(DEPTH));
    if (!reset_n) begin
      st_next = '0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  // Memory write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wr_ptr] <= in_data;
    end
  end
endmodule // sample_fifo
`default_nettype wire

// *** logic/signal_path_pkg.sv ***
/*
  Shared constants and carriers for the field conditioning path.
  Assumes a single 10 MHz clock and a synchronous active-low reset.
*/
// Function
// - Output is (field plus offset) times sensitivity
// - Sensitivity is second-order temperature polynomial
// - Offset is first-order temperature polynomial
// - Customer compensation follows factory compensation
// - Values are fractions within minus one, one
// - Field result is 16-bit two's complement
// - Overflow saturates, never wraps
// - Compensated value goes to field result
// - Results read negative overflow until valid
// - Latch field result at each message start
// - Application mode streams, programming mode does not
// - Low-pass filter, order two, 32 Hz-2 kHz (code uses first order at 1 and 2 kHz)
// - Meaningful result bits 13 to 16
// - Temperature kept as 16-bit two's complement
// - Temperature refreshed faster than 100 ms
// - Parameters come from configuration memory area
// - Range setting selects converter full scale
// - Sensitivity coefficients 12, 9, 8 bits
// - Offset coefficients 10 and 7 bits
`default_nettype none
package signal_path_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 500000;      // Base sample tick, 0.5 ms
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TEMP_REFRESH_MS = 50;         // Well inside the 100 ms bound
  localparam int TEMP_REFRESH_CYCLES = TEMP_REFRESH_MS * 1000000 / CLK_PERIOD_NS;
  // Result words
  localparam logic [15:0] RESULT_RESET = 16'h8000;
  localparam logic [15:0] RESULT_MAX = 16'h7FFF;
  localparam logic [15:0] RESULT_MIN = 16'h8000;
  // Fixed point alignment of the polynomial terms
  localparam int SENS_FRAC = 12;               // Sensitivity 1.0 = 4096
  localparam int SENS_CONST_SHL = 1;
  localparam int SENS_LIN_SHR = 11;
  localparam int SENS_QUAD_SHR = 25;
  localparam int OFF_CONST_SHL = 6;
  localparam int OFF_LIN_SHR = 6;
  // Filter sample selection codes
  localparam logic [4:0] FS_2000HZ = 5'h00;
  localparam logic [4:0] FS_1000HZ = 5'h01;
  localparam logic [4:0] FS_500HZ = 5'h03;
  localparam logic [4:0] FS_250HZ = 5'h07;
  localparam logic [4:0] FS_125HZ = 5'h0B;
  localparam logic [4:0] FS_62HZ = 5'h0F;
  localparam logic [4:0] FS_31HZ = 5'h13;
  localparam int FIFO_DEPTH = 32;

  // Signal processing parameters read from the configuration area
  typedef struct packed {
    logic signed [11:0] sens_const_coef;
    logic signed [8:0] sens_linear_coef;
    logic signed [7:0] sens_quadratic_coef;
    logic signed [9:0] offset_const_coef;
    logic signed [6:0] offset_linear_coef;
    logic [4:0] filter_sample_select;
    logic [2:0] range_select;             // 0 = 20 mT, step 20 mT
  } coef_type;
endpackage
`default_nettype wire

// *** sim/sent_receiver_model.sv ***
/*
  Receiving end of the message link, reduced to the latch handshake.
  Assumes the bench asks for a message with a one-cycle send pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module sent_receiver_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic send,
  output logic message_start,
  input wire logic [15:0] sent_field_word,
  input wire logic sent_field_valid,
  output logic [15:0] rx_word,
  output logic [7:0] rx_count
);
  // Frame start and capture; counting every valid cycle exposes long pulses
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      message_start <= 1'b0;
      rx_word <= 16'h0000;
      rx_count <= 8'h00;
    end else begin
      message_start <= send;
      if (sent_field_valid) begin
        rx_word <= sent_field_word;
        rx_count <= rx_count + 8'h01;
      end
    end
  end
endmodule // sent_receiver_model
`default_nettype wire

// *** sim/test_magnetic_field_signal_path.sv ***
/*
  Bench for the field path: reset values, temperature capture,
  compensation, saturation, message latch and the sample queue.
  Assumes shortened tick and refresh counts and the receiver model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_magnetic_field_signal_path;
  logic clk;
  logic reset_n;
  logic [15:0] fld;
  logic fld_v;
  logic fld_rdy;
  logic [19:0] temp;
  logic temp_v;
  signal_path_pkg::coef_type cfg;
  logic load;
  logic prog;
  logic send;
  logic mstart;
  logic [15:0] res;
  logic [15:0] tres;
  logic [15:0] sword;
  logic svalid;
  logic [2:0] rng;
  logic treq;
  logic [15:0] rx_word;
  logic [7:0] rx_count;
  int fails;
  int n_checks;
  int cycles;

  // Short counts keep the run brief
  magnetic_field_signal_path #(.TICK_CYCLES(4), .TEMP_REFRESH_CYCLES(20)) dut (
    .clk(clk), .reset_n(reset_n), .factory_comp_field(fld),
    .factory_comp_valid(fld_v), .factory_comp_ready(fld_rdy),
    .temperature_raw(temp), .temperature_raw_valid(temp_v),
    .temperature_request(treq), .config_area(cfg), .config_load(load),
    .programming_mode(prog), .message_start(mstart),
    .field_result_reg(res), .temperature_result_reg(tres),
    .sent_field_word(sword), .sent_field_valid(svalid), .range_select(rng)
  );

  sent_receiver_model rx (
    .clk(clk), .reset_n(reset_n), .send(send), .message_start(mstart),
    .sent_field_word(sword), .sent_field_valid(svalid),
    .rx_word(rx_word), .rx_count(rx_count)
  );

  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 5000) begin
        fails++;
        report_and_stop();
      end
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Load only the fields that the scenarios vary
  task automatic cfg_go(input logic [11:0] c0, input logic [9:0] d0, input logic [4:0] fs);
    cfg.sens_const_coef <= c0;
    cfg.offset_const_coef <= d0;
    cfg.filter_sample_select <= fs;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    @(posedge clk);
  endtask

  // Offer one value; ready read at negedge, where it is settled
  task automatic push(input logic [15:0] v, input int n, output int took);
    took = 0;
    fld <= v;
    fld_v <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (fld_rdy === 1'b1) took++;
      @(posedge clk);
    end
    fld_v <= 1'b0;
  endtask

  task automatic set_temp(input logic [19:0] t, input logic [15:0] exp);
    temp <= t;
    temp_v <= 1'b1;
    @(posedge clk);
    temp_v <= 1'b0;
    @(posedge clk);
    chk(tres, exp);
  endtask

  task automatic t_reset();
    chk(res, 16'h8000);
    chk(tres, 16'h8000);
    chk({15'h0000, svalid}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_temp();
    set_temp(20'h12345, 16'h7FFF);
    set_temp(20'hF0000, 16'h8000);
    set_temp(20'h00800, 16'h0800);
    $display("test temp done");
  endtask

  // Low three bits cleared at code 00 hide filter truncation
  task automatic t_comp();
    int took;
    cfg.sens_linear_coef <= 9'h002;
    cfg.sens_quadratic_coef <= 8'h08;
    cfg.offset_linear_coef <= 7'h01;
    cfg.range_select <= 3'h5;
    cfg_go(12'h400, 10'h010, 5'h00);
    push(16'h0FAD, 40, took);
    repeat (300) @(posedge clk);
    chk(res & 16'hFFF8, 16'h09E8);
    chk({13'h0000, rng}, 16'h0005);
    $display("test comp done");
  endtask

  task automatic t_sent();
    logic [7:0] n0;
    n0 = rx_count;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (4) @(posedge clk);
    chk({8'h00, rx_count}, {8'h00, n0 + 8'h01});
    chk(rx_word & 16'hFFF8, 16'h09E8);
    prog <= 1'b1;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (4) @(posedge clk);
    chk({8'h00, rx_count}, {8'h00, n0 + 8'h01});
    prog <= 1'b0;
    $display("test sent done");
  endtask

  task automatic t_sat();
    int took;
    cfg_go(12'h7FF, 10'h1FF, 5'h00);
    push(16'h7000, 40, took);
    repeat (300) @(posedge clk);
    chk(res & 16'hFFF8, 16'h7FF8);
    cfg_go(12'h7FF, 10'h200, 5'h00);
    push(16'h9000, 40, took);
    repeat (300) @(posedge clk);
    chk(res & 16'hFFF8, 16'h8000);
    $display("test sat done");
  endtask

  // Refresh pulses counted at negedge over two refresh periods
  task automatic t_treq();
    int n;
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (treq === 1'b1) n++;
    end
    chk(16'(n), 16'h0002);
    $display("test treq done");
  endtask

  // Slow sampling stalls the consumer, so the queue fills and refuses
  task automatic t_fifo();
    int took;
    cfg_go(12'h400, 10'h010, 5'h13);
    push(16'h0FAD, 60, took);
    chk(16'(took >= 32 && took <= 35), 16'h0001);
    cfg_go(12'h400, 10'h010, 5'h00);
    repeat (200) @(posedge clk);
    chk({15'h0000, fld_rdy}, 16'h0001);
    $display("test fifo done");
  endtask

  // Main sequence
  initial begin
    fails = 0;
    n_checks = 0;
    reset_n = 1'b0;
    fld = 16'h0000;
    fld_v = 1'b0;
    temp = 20'h00000;
    temp_v = 1'b0;
    cfg = '0;
    load = 1'b0;
    prog = 1'b0;
    send = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_temp();
    t_comp();
    t_sent();
    t_sat();
    t_fifo();
    t_treq();
    report_and_stop();
  end
endmodule // test_magnetic_field_signal_path
`default_nettype wire
